// ==== mipr_resolver.v ====
// Maskable interrupt acceptance and priority resolution for the CPU.
// Assumes the sequencer and peripheral sources run on clk_sys; only nmi_n is a pin.
//
// Overview of operation
// - Global enable flag passes all maskable requests when 1, blocks when 0; resets 0.
// - Enable change by return-from-interrupt applies during that same instruction.
// - Enable change by clear, set, pop or load control applies from next instruction.
// - A source raising a request sets its pending bit.
// - Accepting a request and branching clears that source's pending bit.
// - Three-bit source level encodes 0 to 7; 0 disables, 7 is highest.
// - Accept only with enable 1, pending 1 and level above processor level.
// - Processor level n enables only levels above n; 7 blocks all maskable.
// - Enable, pending bits, source levels and processor level are stored separately.
// - Processor level from return-from-interrupt counts 2 cycles after its last cycle.
// - Processor level from pop, load or load-level counts 3 cycles after last cycle.
// - Source level written by a move counts 2 cycles after the write.
// - With several requests pending, only the highest priority one is accepted.
// - Equal programmed levels resolve by fixed hardware order, lower index first.
// - Special order: reset, pin, debugger, watchdog, peripherals, single step, address match.
// - Software interrupts skip priority comparison and always branch.
// - On branching, enable flag clears and processor level takes accepted level.
// - A request losing on priority stays pending until a lower processor level.
// - Each source has its own control register with pending bit and level.
// - Enable flag and processor level live in the flag register.

`timescale 1ns/100ps
`default_nettype none
`include "mipr_resolver_regs.vh"

module mipr_resolver #(
	parameter N_SRC = 29
) (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        arst_n,
	// Register port
	input  wire [6:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// Peripheral request pulses
	input  wire [N_SRC-1:0] src_irq,
	// Special sources
	input  wire        nmi_n,
	input  wire        debugger_irq,
	input  wire        watchdog_irq,
	input  wire        single_step_irq,
	input  wire        addr_match_irq,
	// Instruction sequencer
	input  wire        instr_boundary,
	input  wire        instr_done,
	input  wire [2:0]  instr_op,
	input  wire        instr_i_val,
	input  wire [2:0]  instr_ipl_val,
	input  wire        sw_irq,
	input  wire [5:0]  sw_irq_num,
	// Accepted interrupt
	output reg         irq_take,
	output reg  [2:0]  irq_class,
	output reg  [5:0]  irq_id,
	output reg  [2:0]  irq_level,
	// Flag register state
	output reg         i_flag,
	output reg  [2:0]  processor_priority_level
);

	// Per-source storage
	reg        req_bit [0:N_SRC-1];
	reg [2:0]  lvl     [0:N_SRC-1];
	reg [2:0]  lvl_d1  [0:N_SRC-1];
	reg [2:0]  lvl_eff [0:N_SRC-1];

	// Effective acceptance state
	reg        i_eff;
	reg        i_arm;
	reg [2:0]  ipl_eff;
	reg [2:0]  ipl_next;
	reg [2:0]  ipl_cnt;

	// Special request latches
	reg        nmi_s1;
	reg        nmi_s2;
	reg        nmi_prev;
	reg        nmi_pend;
	reg        dbg_pend;
	reg        wdt_pend;
	reg        step_pend;
	reg        amatch_pend;

	// Resolution results
	reg        best_hit;
	reg [2:0]  best_lvl;
	reg [5:0]  best_idx;
	reg        take_now;
	reg [2:0]  next_class;
	reg [5:0]  next_id;
	reg [2:0]  next_level;
	reg [7:0]  next_rdata;

	integer    i;
	integer    j;
	integer    k;

	wire       nmi_fall = nmi_prev & ~nmi_s2;
	wire       op_load_i = (instr_op == `MIPR_OP_FLAG_CLEAR_INSTR) | (instr_op == `MIPR_OP_FLAG_SET_INSTR) |
	                       (instr_op == `MIPR_OP_POP_CONTROL_INSTR) | (instr_op == `MIPR_OP_LDC);
	wire       op_load_ipl = (instr_op == `MIPR_OP_POP_CONTROL_INSTR) | (instr_op == `MIPR_OP_LDC) |
	                         (instr_op == `MIPR_OP_LOAD_PRIORITY_LEVEL_INSTR);
	wire       periph_win = take_now & (next_class == `MIPR_CLS_PERIPH);

	// Pin synchroniser; first stage feeds only the second
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			nmi_s1   <= 1'b1;
			nmi_s2   <= 1'b1;
			nmi_prev <= 1'b1;
		end else begin
			nmi_s1   <= nmi_n;
			nmi_s2   <= nmi_s1;
			nmi_prev <= nmi_s2;
		end
	end

	// Highest level among eligible sources; lower index wins ties
	always @* begin
		best_hit = 1'b0;
		best_lvl = `MIPR_LVL_OFF;
		best_idx = 6'h00;
		for (i = 0; i < N_SRC; i = i + 1) begin
			if (req_bit[i] && (lvl_eff[i] > ipl_eff) && (!best_hit || lvl_eff[i] > best_lvl)) begin
				best_hit = 1'b1;
				best_lvl = lvl_eff[i];
				best_idx = i[5:0];
			end
		end
	end

	// Fixed order of the special sources around the peripherals
	always @* begin
		take_now   = 1'b0;
		next_class = `MIPR_CLS_NONE;
		next_id    = 6'h00;
		next_level = processor_priority_level;
		if (sw_irq) begin
			take_now   = 1'b1;
			next_class = `MIPR_CLS_SW;
			next_id    = sw_irq_num;
		end else if (instr_boundary) begin
			if (nmi_pend) begin
				take_now   = 1'b1;
				next_class = `MIPR_CLS_NMI;
			end else if (dbg_pend) begin
				take_now   = 1'b1;
				next_class = `MIPR_CLS_DBG;
			end else if (wdt_pend) begin
				take_now   = 1'b1;
				next_class = `MIPR_CLS_WDT;
			end else if (i_eff && best_hit) begin
				take_now   = 1'b1;
				next_class = `MIPR_CLS_PERIPH;
				next_id    = best_idx;
				next_level = best_lvl;
			end else if (step_pend) begin
				take_now   = 1'b1;
				next_class = `MIPR_CLS_STEP;
			end else if (amatch_pend) begin
				take_now   = 1'b1;
				next_class = `MIPR_CLS_AMATCH;
			end
		end
	end

	// Special pending latches; a new event beats the clear
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			nmi_pend    <= 1'b0;
			dbg_pend    <= 1'b0;
			wdt_pend    <= 1'b0;
			step_pend   <= 1'b0;
			amatch_pend <= 1'b0;
		end else begin
			if (take_now && next_class == `MIPR_CLS_NMI)
				nmi_pend <= 1'b0;
			if (take_now && next_class == `MIPR_CLS_DBG)
				dbg_pend <= 1'b0;
			if (take_now && next_class == `MIPR_CLS_WDT)
				wdt_pend <= 1'b0;
			if (take_now && next_class == `MIPR_CLS_STEP)
				step_pend <= 1'b0;
			if (take_now && next_class == `MIPR_CLS_AMATCH)
				amatch_pend <= 1'b0;
			if (nmi_fall)
				nmi_pend <= 1'b1;
			if (debugger_irq)
				dbg_pend <= 1'b1;
			if (watchdog_irq)
				wdt_pend <= 1'b1;
			if (single_step_irq)
				step_pend <= 1'b1;
			if (addr_match_irq)
				amatch_pend <= 1'b1;
		end
	end

	// Per-source control registers
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (j = 0; j < N_SRC; j = j + 1) begin
				req_bit[j] <= 1'b0;
				lvl[j]     <= `MIPR_LVL_OFF;
				lvl_d1[j]  <= `MIPR_LVL_OFF;
				lvl_eff[j] <= `MIPR_LVL_OFF;
			end
		end else begin
			for (j = 0; j < N_SRC; j = j + 1) begin
				lvl_d1[j]  <= lvl[j];
				lvl_eff[j] <= lvl_d1[j];
				if (reg_wr && reg_addr == j[6:0]) begin
					lvl[j] <= reg_wdata[`MIPR_CTL_LVL_MSB:`MIPR_CTL_LVL_LSB];
					if (!reg_wdata[`MIPR_CTL_REQ_BIT])
						req_bit[j] <= 1'b0;
				end
				if (periph_win && next_id == j[5:0])
					req_bit[j] <= 1'b0;
				if (src_irq[j])
					req_bit[j] <= 1'b1;
			end
		end
	end

	// Flag register: enable flag and processor level
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			i_flag                   <= `MIPR_I_RST;
			i_eff                    <= `MIPR_I_RST;
			i_arm                    <= 1'b0;
			processor_priority_level <= `MIPR_IPL_RST;
			ipl_eff                  <= `MIPR_IPL_RST;
			ipl_next                 <= `MIPR_IPL_RST;
			ipl_cnt                  <= 3'h0;
		end else if (take_now) begin
			// Branch state takes hold at once
			i_flag                   <= 1'b0;
			i_eff                    <= 1'b0;
			i_arm                    <= 1'b0;
			processor_priority_level <= next_level;
			ipl_eff                  <= next_level;
			ipl_cnt                  <= 3'h0;
		end else begin
			if (instr_boundary && i_arm) begin
				i_eff <= i_flag;
				i_arm <= 1'b0;
			end
			if (ipl_cnt == 3'h1)
				ipl_eff <= ipl_next;
			if (ipl_cnt != 3'h0)
				ipl_cnt <= ipl_cnt - 3'h1;
			if (instr_done) begin
				case (instr_op)
				`MIPR_OP_RET: begin
					i_flag                   <= instr_i_val;
					i_eff                    <= instr_i_val;
					i_arm                    <= 1'b0;
					processor_priority_level <= instr_ipl_val;
					ipl_next                 <= instr_ipl_val;
					ipl_cnt                  <= `MIPR_IPL_DLY_RET;
				end
				`MIPR_OP_FLAG_CLEAR_INSTR: begin
					i_flag <= 1'b0;
					i_arm  <= 1'b1;
				end
				`MIPR_OP_FLAG_SET_INSTR: begin
					i_flag <= 1'b1;
					i_arm  <= 1'b1;
				end
				`MIPR_OP_POP_CONTROL_INSTR, `MIPR_OP_LDC: begin
					i_flag                   <= instr_i_val;
					i_arm                    <= 1'b1;
					processor_priority_level <= instr_ipl_val;
					ipl_next                 <= instr_ipl_val;
					ipl_cnt                  <= `MIPR_IPL_DLY_LOAD;
				end
				`MIPR_OP_LOAD_PRIORITY_LEVEL_INSTR: begin
					processor_priority_level <= instr_ipl_val;
					ipl_next                 <= instr_ipl_val;
					ipl_cnt                  <= `MIPR_IPL_DLY_LOAD;
				end
				default: begin
					i_arm <= i_arm;
				end
				endcase
			end
		end
	end

	// Accepted interrupt report
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_take  <= 1'b0;
			irq_class <= `MIPR_CLS_NONE;
			irq_id    <= 6'h00;
			irq_level <= `MIPR_LVL_OFF;
		end else begin
			irq_take <= take_now;
			if (take_now) begin
				irq_class <= next_class;
				irq_id    <= next_id;
				irq_level <= next_level;
			end
		end
	end

	// Register read mux
	always @* begin
		next_rdata = 8'h00;
		if (reg_addr < N_SRC) begin
			for (k = 0; k < N_SRC; k = k + 1) begin
				if (reg_addr == k[6:0])
					next_rdata = {4'h0, req_bit[k], lvl[k]};
			end
		end else if (reg_addr == `MIPR_FLG_IDX) begin
			next_rdata = {1'b0, processor_priority_level, 3'h0, i_flag};
		end else if (reg_addr == `MIPR_STAT_IDX) begin
			next_rdata = {1'b0, ipl_eff, 3'h0, i_eff};
		end
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= 8'h00;
	end

endmodule // mipr_resolver

`default_nettype wire

// ==== mipr_resolver_asserts.sv ====
// Port-level checker for mipr_resolver.
// Assumes a bind onto mipr_resolver; one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "mipr_resolver_regs.vh"
module mipr_chk #(
	parameter N_SRC = 29
) (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       arst_n,
	// Register port
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Sequencer side
	input wire logic       instr_boundary,
	input wire logic       instr_done,
	input wire logic       sw_irq,
	input wire logic [5:0] sw_irq_num,
	// Accepted interrupt and flags
	input wire logic       irq_take,
	input wire logic [2:0] irq_class,
	input wire logic [5:0] irq_id,
	input wire logic [2:0] irq_level,
	input wire logic       i_flag,
	input wire logic [2:0] processor_priority_level
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence flag_rd_s;
		reg_rd && reg_addr == `MIPR_FLG_IDX;
	endsequence
	sequence lvl_wr_rd_s;
		reg_wr && reg_addr < N_SRC ##1 reg_rd && reg_addr == $past(reg_addr);
	endsequence

	take_clears_i_a: assert property (irq_take |-> !i_flag)
		else $error("enable flag still set at take");
	take_level_a: assert property (irq_take && irq_class == `MIPR_CLS_PERIPH |->
		processor_priority_level == irq_level && irq_level != 3'h0)
		else $error("peripheral take level wrong");
	sw_always_a: assert property (sw_irq |=> irq_take && irq_class == `MIPR_CLS_SW
		&& irq_id == $past(sw_irq_num))
		else $error("software interrupt not taken");
	take_at_sample_a: assert property (irq_take |-> $past(instr_boundary || sw_irq))
		else $error("take without sampling point");
	flag_image_a: assert property (flag_rd_s |=>
		reg_rdata == {1'b0, $past(processor_priority_level), 3'b000, $past(i_flag)})
		else $error("flag image read wrong");
	lvl_store_a: assert property (lvl_wr_rd_s |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
		else $error("level readback wrong");
	enable_cause_a: assert property ($rose(i_flag) |-> $past(instr_done))
		else $error("enable flag set without instruction");
	level_cause_a: assert property ($changed(processor_priority_level) |->
		irq_take || $past(instr_done))
		else $error("processor level changed without cause");
endmodule // mipr_chk

bind mipr_resolver mipr_chk #(.N_SRC(N_SRC)) i_mipr_chk (.clk_sys, .arst_n, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .instr_boundary, .instr_done, .sw_irq, .sw_irq_num, .irq_take,
	.irq_class, .irq_id, .irq_level, .i_flag, .processor_priority_level);
`default_nettype wire

// ==== mipr_resolver_regs.vh ====
// Constants for the maskable interrupt priority resolver.
// Assumes inclusion by mipr_resolver.v, its checker and its bench; definitions only.
`ifndef MIPR_RESOLVER_REGS_VH
`define MIPR_RESOLVER_REGS_VH

// Per-source control register layout, register index = source number
`define MIPR_CTL_REQ_BIT     3
`define MIPR_CTL_LVL_MSB     2
`define MIPR_CTL_LVL_LSB     0
`define MIPR_CTL_RST         8'h00

// Flag register image (read only over the bus)
`define MIPR_FLG_IDX         7'h40
`define MIPR_FLG_I_BIT       0
`define MIPR_FLG_IPL_LSB     4
`define MIPR_FLG_IPL_MSB     6

// Effective acceptance state
`define MIPR_STAT_IDX        7'h41

// Reset values
`define MIPR_I_RST           1'b0
`define MIPR_IPL_RST         3'h0
`define MIPR_LVL_OFF         3'h0
`define MIPR_IPL_ALL_OFF     3'h7

// Cycles from last instruction cycle to new level taking effect
`define MIPR_IPL_DLY_RET     3'h2
`define MIPR_IPL_DLY_LOAD    3'h3
`define MIPR_LVL_DLY         2

// Instruction codes from the sequencer
`define MIPR_OP_NONE         3'h0
`define MIPR_OP_RET          3'h1
`define MIPR_OP_FLAG_CLEAR_INSTR         3'h2
`define MIPR_OP_FLAG_SET_INSTR         3'h3
`define MIPR_OP_POP_CONTROL_INSTR         3'h4
`define MIPR_OP_LDC          3'h5
`define MIPR_OP_LOAD_PRIORITY_LEVEL_INSTR        3'h6
`define MIPR_OP_MOVE         3'h7

// Accepted interrupt class; codes 1 to 6 in fixed hardware order, software taken first
`define MIPR_CLS_NONE        3'h0
`define MIPR_CLS_NMI         3'h1
`define MIPR_CLS_DBG         3'h2
`define MIPR_CLS_WDT         3'h3
`define MIPR_CLS_PERIPH      3'h4
`define MIPR_CLS_STEP        3'h5
`define MIPR_CLS_AMATCH      3'h6
`define MIPR_CLS_SW          3'h7

`endif

// ==== mipr_seq_model.sv ====
// Sequencer model: instruction boundary pulses at a set spacing.
// Assumes clk_sys and arst_n are shared with the resolver.
`timescale 1ns/100ps
`default_nettype none
module mipr_seq_model (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       arst_n,
	// Cycles between boundaries
	input wire logic [3:0] gap,
	// Sampling point
	output logic           instr_boundary
);
	logic [3:0] cnt;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 4'h0;
			instr_boundary <= 1'b0;
		end else begin
			instr_boundary <= (cnt == 4'h0);
			cnt <= (cnt == 4'h0) ? gap : cnt - 4'h1;
		end
	end
endmodule // mipr_seq_model
`default_nettype wire

// ==== tb_mipr_resolver.sv ====
// Self-checking bench for mipr_resolver.
// Assumes the resolver, its checker and the sequencer model.
`timescale 1ns/100ps
`default_nettype none
`include "mipr_resolver_regs.vh"
module tb_mipr_resolver;
	localparam int N = 29;
	logic          clk_sys = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, nmi_n = 1;
	logic          debugger_irq = 0, watchdog_irq = 0, single_step_irq = 0, addr_match_irq = 0;
	logic          instr_done = 0, instr_i_val = 0, sw_irq = 0, rd_pend = 0, irq_take, i_flag;
	logic [6:0]    reg_addr = '0;
	logic [7:0]    reg_wdata = '0, reg_rdata;
	logic [N-1:0]  src_irq = '0;
	logic [2:0]    instr_op = '0, instr_ipl_val = '0, irq_class, irq_level, processor_priority_level;
	logic [5:0]    sw_irq_num = '0, irq_id;
	logic [3:0]    gap = 4'h3;
	logic [31:0]   seed = 32'h0000_9de1;
	logic [7:0]    exp_rd[$];
	logic [11:0]   exp_tk[$];
	wire           instr_boundary;
	int            fails = 0, tests_run = 0;

	mipr_resolver #(.N_SRC(N)) i_mipr_resolver (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .src_irq, .nmi_n, .debugger_irq, .watchdog_irq, .single_step_irq, .addr_match_irq,
		.instr_boundary, .instr_done, .instr_op, .instr_i_val, .instr_ipl_val, .sw_irq, .sw_irq_num,
		.irq_take, .irq_class, .irq_id, .irq_level, .i_flag, .processor_priority_level);
	mipr_seq_model i_mipr_seq_model (.clk_sys, .arst_n, .gap, .instr_boundary);

	initial forever #10 clk_sys = ~clk_sys;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Every pulse input assigned once per edge
	task automatic step(input logic w, r, d, s, input logic [N-1:0] v = '0, input logic [3:0] sp = '0);
		reg_wr <= w;
		reg_rd <= r;
		instr_done <= d;
		sw_irq <= s;
		src_irq <= v;
		{debugger_irq, watchdog_irq, single_step_irq, addr_match_irq} <= sp;
		@(posedge clk_sys);
	endtask
	task automatic ticks(input int n);
		repeat (n) step(0, 0, 0, 0);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		step(1, 0, 0, 0);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		exp_rd.push_back(e);
		reg_addr <= a;
		step(0, 1, 0, 0);
	endtask
	task automatic op(input logic [2:0] o, input logic i, input logic [2:0] l);
		instr_op <= o;
		instr_i_val <= i;
		instr_ipl_val <= l;
		step(0, 0, 1, 0);
	endtask
	task automatic tk(input logic [2:0] c, input logic [5:0] id, input logic [2:0] l);
		exp_tk.push_back({c, id, l});
	endtask
	task automatic chk_rd(input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("mismatch reg_rdata expected %h seen %h", e, s);
		end
	endtask
	task automatic chk_tk(input logic [11:0] e, input logic [11:0] s);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("mismatch take expected %h seen %h", e, s);
		end
	endtask
	task automatic drain;
		for (int k = 0; k < 300 && exp_tk.size() > 0; k++) ticks(1);
		chk_tk(12'h000, 12'(exp_tk.size()));
		ticks(6);
	endtask
	task automatic give_verdict;
		$display("checks %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Results checked in arrival order
	always @(negedge clk_sys) begin
		if (rd_pend)
			chk_rd(exp_rd.pop_front(), reg_rdata);
		if (irq_take === 1'b1)
			chk_tk(exp_tk.size() ? exp_tk.pop_front() : 12'hfff, {irq_class, irq_id, irq_level});
		rd_pend = reg_rd;
	end

	initial begin
		#100000;
		fails++;
		give_verdict;
	end

	initial begin
		ticks(10);
		arst_n <= 1'b1;
		ticks(1);
		rd(`MIPR_FLG_IDX, 8'h00);
		rd(7'h50, 8'h00);
		rd(7'h00, 8'h00);
		wr(7'h07, 8'h06);
		rd(7'h07, 8'h06);
		wr(7'h03, 8'h05);
		wr(7'h01, 8'h05);
		wr(7'h02, 8'h04);
		step(0, 0, 0, 0, 29'h0000_008e);
		ticks(1);
		wr(7'h02, 8'h04);
		rd(7'h03, 8'h0d);
		rd(7'h02, 8'h04);
		ticks(12);
		tk(`MIPR_CLS_PERIPH, 6'h07, 3'h6);
		op(`MIPR_OP_FLAG_SET_INSTR, 1'b1, 3'h0);
		drain;
		rd(`MIPR_FLG_IDX, 8'h60);
		tk(`MIPR_CLS_PERIPH, 6'h01, 3'h5);
		op(`MIPR_OP_RET, 1'b1, 3'h0);
		drain;
		tk(`MIPR_CLS_PERIPH, 6'h03, 3'h5);
		op(`MIPR_OP_RET, 1'b1, 3'h0);
		drain;
		rd(7'h03, 8'h05);
		gap <= 4'h9;
		op(`MIPR_OP_LOAD_PRIORITY_LEVEL_INSTR, 1'b0, 3'h7);
		op(`MIPR_OP_FLAG_SET_INSTR, 1'b1, 3'h0);
		step(0, 0, 0, 0, 29'h0000_0080);
		ticks(30);
		tk(`MIPR_CLS_PERIPH, 6'h07, 3'h6);
		op(`MIPR_OP_RET, 1'b1, 3'h5);
		drain;
		tk(`MIPR_CLS_DBG, 6'h00, 3'h6);
		tk(`MIPR_CLS_WDT, 6'h00, 3'h6);
		tk(`MIPR_CLS_STEP, 6'h00, 3'h6);
		tk(`MIPR_CLS_AMATCH, 6'h00, 3'h6);
		step(0, 0, 0, 0, '0, 4'b1111);
		drain;
		tk(`MIPR_CLS_NMI, 6'h00, 3'h6);
		nmi_n <= 1'b0;
		ticks(6);
		nmi_n <= 1'b1;
		drain;
		gap <= 4'h2;
		repeat (3) begin
			seed = lfsr(seed);
			tk(`MIPR_CLS_SW, seed[5:0], 3'h6);
			sw_irq_num <= seed[5:0];
			step(0, 0, 0, 1);
			ticks(3);
		end
		drain;
		give_verdict;
	end
endmodule // tb_mipr_resolver
`default_nettype wire
